// [rtl/iods_top.sv]
// The address-and-strobe port and the address map were decided locally.
`include "iods_map.svh"
module iods_top #(
    parameter int TAPS  = 256,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output      logic [31:0] rdata,
    // Link
    input  wire logic       link_clk,
    input  wire logic       pin_in,
    output      logic       pin_out,
    output      logic       pin_oe_b
);
    // ************************************************************
    // Declarations
    // ************************************************************
    iods_pkg::iods_ctrl_s ctrl_reg;
    iods_pkg::iods_cal_e  cal_reg;
    logic [7:0]  tap_reg;
    logic [8:0]  cal_cnt_reg;
    logic        cal_done_reg;
    logic [2:0]  lclk_reg;
    logic [1:0]  din_reg;
    logic        in_q_reg;
    logic        out_q_reg;
    logic        prev_reg;
    logic        ev_d_reg;
    logic [7:0]  rx_sh_reg;
    logic [3:0]  rx_cnt_reg;
    logic [7:0]  tx_sh_reg;
    logic [3:0]  tx_cnt_reg;
    logic        tx_bit_reg;
    logic        ovf_reg;
    logic        pin_out_reg;
    logic        pin_oe_b_reg;
    logic [31:0] rdata_reg;
    logic        rise;
    logic        fall;
    logic        shift_ev;
    logic        dly_in;
    logic        dly_out;
    logic        rx_bit;
    logic [3:0]  wid;
    logic        rx_on;
    logic        word_done;
    logic        fifo_ready;
    logic        fifo_valid;
    logic [7:0]  fifo_data;
    logic        fifo_pop;
    logic [$clog2(DEPTH):0] fifo_level;
    logic        sw_inc;
    logic        sw_dec;
    logic        pd_inc;
    logic        pd_dec;
    logic        cal_go;
    logic        cal_load;

    // ************************************************************
    // Functions
    // ************************************************************
    // Single pins limited to 4 bits, pairs to 8, never below 2
    function automatic logic [3:0] eff_width(input logic [3:0] w, input logic diff);
        logic [3:0] lim;
        lim = diff ? `IODS_WID_MAX : `IODS_WID_PIN;
        if (w < `IODS_WID_MIN) begin
            return `IODS_WID_MIN;
        end else if (w > lim) begin
            return lim;
        end
        return w;
    endfunction

    // Saturating one-tap step
    function automatic logic [7:0] tap_step(input logic [7:0] t, input logic up, input logic dn);
        if (up && !dn && t != `IODS_TAP_MAX) begin
            return t + 8'h01;
        end else if (dn && !up && t != `IODS_TAP_RST) begin
            return t - 8'h01;
        end
        return t;
    endfunction

    // ************************************************************
    // Pin synchronisers and link clock edges
    // ************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lclk_reg <= 3'h0;
            din_reg  <= 2'h0;
        end else begin
            lclk_reg <= {lclk_reg[1:0], link_clk};
            din_reg  <= {din_reg[0], pin_in};
        end
    end

    // Fast clock shifts once per rising edge; doubling on both edges
    assign rise     = lclk_reg[1] & ~lclk_reg[2];
    assign fall     = ~lclk_reg[1] & lclk_reg[2];
    assign shift_ev = ctrl_reg.en & (rise | (ctrl_reg.ddr & fall));
    assign wid      = eff_width(ctrl_reg.width, ctrl_reg.diff);

    // ************************************************************
    // Delay line shared by both directions
    // ************************************************************
    assign dly_in = ctrl_reg.dir_out ? tx_bit_reg : din_reg[1];

    iods_tap_line #(
        .TAPS (TAPS)
    ) u_tap (
        .clock (clock),
        .rst_b (rst_b),
        .din   (dly_in),
        .tap   (tap_reg),
        .dout  (dly_out)
    );

    // Registered copies for the registered paths and the phase detector
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            in_q_reg  <= 1'b0;
            out_q_reg <= 1'b0;
            prev_reg  <= 1'b0;
            ev_d_reg  <= 1'b0;
        end else begin
            in_q_reg  <= dly_out;
            out_q_reg <= dly_out;
            prev_reg  <= dly_out;
            ev_d_reg  <= shift_ev;
        end
    end

    assign rx_bit = ctrl_reg.reg_in ? in_q_reg : dly_out;

    // ************************************************************
    // Register write side
    // ************************************************************
    assign sw_inc = wr && addr == `IODS_OFS_STEP && wdata[`IODS_STEP_INC];
    assign sw_dec = wr && addr == `IODS_OFS_STEP && wdata[`IODS_STEP_DEC];
    assign cal_go = wr && addr == `IODS_OFS_STEP && wdata[`IODS_STEP_CAL] && ctrl_reg.cal_en;

    // Control register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= iods_pkg::iods_ctrl_s'(`IODS_CTRL_RST);
        end else if (wr && addr == `IODS_OFS_CTRL) begin
            ctrl_reg <= iods_pkg::iods_ctrl_s'(wdata[11:0]);
        end
    end

    // ************************************************************
    // Phase detector: transition at the sample point is too early,
    // transition one cycle after is too late
    // ************************************************************
    assign rx_on  = ctrl_reg.en & ~ctrl_reg.dir_out;
    assign pd_inc = ctrl_reg.pd_en & ctrl_reg.diff & rx_on & shift_ev & (dly_out != prev_reg);
    assign pd_dec = ctrl_reg.pd_en & ctrl_reg.diff & rx_on & ev_d_reg & (dly_out != prev_reg);

    // ************************************************************
    // Tap value
    // ************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tap_reg <= `IODS_TAP_RST;
        end else if (cal_load) begin
            tap_reg <= (cal_cnt_reg[8:1] > `IODS_TAP_MAX) ? `IODS_TAP_MAX : cal_cnt_reg[8:1];
        end else if (wr && addr == `IODS_OFS_TAP) begin
            tap_reg <= wdata[7:0];
        end else begin
            tap_reg <= tap_step(tap_reg, sw_inc | pd_inc, sw_dec | pd_dec);
        end
    end

    // ************************************************************
    // Calibration: count taps over one link clock period
    // ************************************************************
    assign cal_load = (cal_reg == iods_pkg::IODS_CAL_COUNT) && rise;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cal_reg      <= iods_pkg::IODS_CAL_IDLE;
            cal_cnt_reg  <= 9'h000;
            cal_done_reg <= 1'b0;
        end else begin
            case (cal_reg)
                iods_pkg::IODS_CAL_IDLE: begin
                    if (cal_go) begin
                        cal_reg      <= iods_pkg::IODS_CAL_WAIT;
                        cal_done_reg <= 1'b0;
                    end
                end
                iods_pkg::IODS_CAL_WAIT: begin
                    if (rise) begin
                        cal_reg     <= iods_pkg::IODS_CAL_COUNT;
                        cal_cnt_reg <= 9'h001;
                    end
                end
                iods_pkg::IODS_CAL_COUNT: begin
                    if (rise) begin
                        cal_reg      <= iods_pkg::IODS_CAL_IDLE;
                        cal_done_reg <= 1'b1;
                    end else if (cal_cnt_reg != `IODS_CAL_MAX) begin
                        cal_cnt_reg <= cal_cnt_reg + 9'h001;
                    end
                end
                default: begin
                    cal_reg <= iods_pkg::IODS_CAL_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Deserializer, stalls while the FIFO is full
    // ************************************************************
    assign word_done = rx_on & shift_ev & fifo_ready & (rx_cnt_reg == wid - 4'h1);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_sh_reg  <= 8'h00;
            rx_cnt_reg <= 4'h0;
            ovf_reg    <= 1'b0;
        end else begin
            if (rx_on && shift_ev && fifo_ready) begin
                rx_sh_reg  <= {rx_sh_reg[6:0], rx_bit};
                rx_cnt_reg <= word_done ? 4'h0 : rx_cnt_reg + 4'h1;
            end
            if (rx_on && shift_ev && !fifo_ready) begin
                ovf_reg <= 1'b1;
            end else if (wr && addr == `IODS_OFS_STAT) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    assign fifo_pop = rd && addr == `IODS_OFS_RXD;

    iods_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_b     (rst_b),
        .in_valid  (word_done),
        .in_data   ({rx_sh_reg[6:0], rx_bit} & ((8'h01 << wid) - 8'h01)),
        .in_ready  (fifo_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (fifo_pop),
        .level     (fifo_level)
    );

    // ************************************************************
    // Serializer, MSB first, one bit per shift event
    // ************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_sh_reg  <= 8'h00;
            tx_cnt_reg <= 4'h0;
            tx_bit_reg <= 1'b0;
        end else if (wr && addr == `IODS_OFS_TXD && tx_cnt_reg == 4'h0) begin
            tx_sh_reg  <= wdata[7:0] << (4'h8 - wid);
            tx_cnt_reg <= wid;
        end else if (ctrl_reg.dir_out && shift_ev && tx_cnt_reg != 4'h0) begin
            tx_bit_reg <= tx_sh_reg[7];
            tx_sh_reg  <= {tx_sh_reg[6:0], 1'b0};
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
        end
    end

    // Pin drivers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_out_reg  <= 1'b0;
            pin_oe_b_reg <= 1'b1;
        end else begin
            pin_out_reg  <= ctrl_reg.reg_out ? out_q_reg : dly_out;
            pin_oe_b_reg <= ~(ctrl_reg.en & ctrl_reg.dir_out);
        end
    end

    // ************************************************************
    // Read side, data one cycle after the strobe
    // ************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 32'h0000_0000;
        end else if (!rd) begin
            rdata_reg <= 32'h0000_0000;
        end else if (addr == `IODS_OFS_CTRL) begin
            rdata_reg <= {20'h00000, ctrl_reg};
        end else if (addr == `IODS_OFS_TAP) begin
            rdata_reg <= {24'h000000, tap_reg};
        end else if (addr == `IODS_OFS_RXD) begin
            rdata_reg <= {23'h000000, fifo_valid, fifo_valid ? fifo_data : 8'h00};
        end else if (addr == `IODS_OFS_STAT) begin
            rdata_reg <= {19'h00000, 8'(fifo_level), 1'b0, ovf_reg, tx_cnt_reg != 4'h0,
                          cal_reg != iods_pkg::IODS_CAL_IDLE, cal_done_reg};
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign rdata    = rdata_reg;
    assign pin_out  = pin_out_reg;
    assign pin_oe_b = pin_oe_b_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    AST_TAP_NO_WRAP_UP: assert property (tap_reg == `IODS_TAP_MAX && sw_inc && !sw_dec && !cal_load
        && !(wr && addr == `IODS_OFS_TAP) |=> tap_reg == `IODS_TAP_MAX)
        else $error("tap wrapped above maximum");
    AST_TAP_NO_WRAP_DN: assert property (tap_reg == `IODS_TAP_RST && sw_dec && !sw_inc && !pd_inc && !cal_load
        && !(wr && addr == `IODS_OFS_TAP) |=> tap_reg == `IODS_TAP_RST)
        else $error("tap wrapped below zero");
    AST_TAP_ONE_STEP: assert property (!cal_load && !(wr && addr == `IODS_OFS_TAP) |=>
        (tap_reg - $past(tap_reg) == 8'h01) || ($past(tap_reg) - tap_reg == 8'h01) || $stable(tap_reg))
        else $error("tap moved by more than one");
    AST_TAP_LOAD: assert property (wr && addr == `IODS_OFS_TAP && !cal_load |=> tap_reg == $past(wdata[7:0]))
        else $error("configured tap not applied");
    AST_CAL_HALF: assert property (cal_load |=> tap_reg == $past(cal_cnt_reg[8:1]) && cal_done_reg)
        else $error("calibration did not load half period");
    AST_PD_DIFF_ONLY: assert property (!ctrl_reg.diff |-> !pd_inc && !pd_dec)
        else $error("phase detector active on single pin");
    AST_WIDTH_RANGE: assert property (wid >= `IODS_WID_MIN && (ctrl_reg.diff || wid <= `IODS_WID_PIN))
        else $error("word width out of range");
    AST_TX_BITS: assert property (wr && addr == `IODS_OFS_TXD && tx_cnt_reg == 4'h0 |=> tx_cnt_reg == $past(wid))
        else $error("serializer loaded wrong width");
    AST_OE_DIR: assert property (ctrl_reg.en && ctrl_reg.dir_out ##1 ctrl_reg.en && ctrl_reg.dir_out
        |=> !pin_oe_b)
        else $error("pin not driven in output direction");
    AST_REG_IN: assert property (ctrl_reg.reg_in && rx_on && shift_ev && fifo_ready |=>
        rx_sh_reg[0] == $past(in_q_reg))
        else $error("registered input path not used");

    COV_WORD: cover property (word_done);
    COV_CAL: cover property (cal_load);
    COV_PD: cover property (pd_inc or pd_dec);
    COV_FULL: cover property (!fifo_ready);
endmodule

// [rtl/iods_map.svh]
`ifndef IODS_MAP_SVH
`define IODS_MAP_SVH
// ************************************************************
// Register offsets
// ************************************************************
`define IODS_OFS_CTRL   8'h00
`define IODS_OFS_TAP    8'h04
`define IODS_OFS_STEP   8'h08
`define IODS_OFS_TXD    8'h0c
`define IODS_OFS_RXD    8'h10
`define IODS_OFS_STAT   8'h14
// ************************************************************
// Field positions and values
// ************************************************************
`define IODS_STEP_INC   0
`define IODS_STEP_DEC   1
`define IODS_STEP_CAL   2
`define IODS_RXD_VALID  8
`define IODS_CTRL_RST   12'h004
`define IODS_TAP_RST    8'h00
`define IODS_TAP_MAX    8'hff
`define IODS_WID_MIN    4'h2
`define IODS_WID_PIN    4'h4
`define IODS_WID_MAX    4'h8
`define IODS_CAL_MAX    9'h1ff
`endif

// [rtl/iods_pkg.sv]
package iods_pkg;
    // ************************************************************
    // Control register layout, highest bit first
    // ************************************************************
    typedef struct packed {
        logic [3:0] width;    // Parallel word width, 2 to 8
        logic       pd_en;    // Phase detector enable
        logic       cal_en;   // Calibration allowed
        logic       diff;     // Differential pair, cascaded converters
        logic       dir_out;  // Line drives outward
        logic       ddr;      // Shift on both link clock edges
        logic       reg_out;  // Registered output path
        logic       reg_in;   // Registered input path
        logic       en;       // Block enable
    } iods_ctrl_s;

    // Calibration sequencer
    typedef enum logic [1:0] {
        IODS_CAL_IDLE  = 2'b00,
        IODS_CAL_WAIT  = 2'b01,
        IODS_CAL_COUNT = 2'b10
    } iods_cal_e;
endpackage

// [rtl/iods_fifo.sv]
module iods_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             in_ready,
    // Draining side
    output      logic             out_valid,
    output      logic [WIDTH-1:0] out_data,
    input  wire logic             out_ready,
    // Fill level
    output      logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    // Handshakes and flags
    assign in_ready  = (cnt_reg != AW'(0) + (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rp_reg];
    assign level     = cnt_reg;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage
    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wp_reg] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + AW'(1);
            end
            if (pop) begin
                rp_reg <= rp_reg + AW'(1);
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [rtl/iods_tap_line.sv]
module iods_tap_line #(
    parameter int TAPS = 256
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    // Line
    input  wire logic                    din,
    input  wire logic [$clog2(TAPS)-1:0] tap,
    output      logic                    dout
);
    logic [TAPS-1:0] hist_reg;

    // One tap is one clock period of delay
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hist_reg <= '0;
        end else begin
            hist_reg <= {hist_reg[TAPS-2:0], din};
        end
    end

    // Tap zero is the undelayed sample
    assign dout = (tap == '0) ? din : hist_reg[tap - 1'b1];
endmodule

// [bench/iods_link_partner.sv]
module iods_link_partner (
    // Lines toward the block
    output logic      link_clk,
    output logic      pin_in,
    // Lines from the block
    input  wire logic pin_out,
    input  wire logic pin_oe_b
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Far end of the serial link
    // ****************************************
    // Clock stands low and line idle before the first frame
    initial begin
        link_clk = 1'h0;
        pin_in   = 1'h0;
    end

    // Sends n bits first bit highest; data leads each rising edge, and with ddr each edge, by 16 ns
    task automatic send(input logic [7:0] w, input int n, input logic ddr);
        #2; // Keeps every line change clear of the block's clock edges
        for (int i = n - 1; i >= 0; i--) begin
            pin_in = w[i];
            #16;
            link_clk = ddr ? ~link_clk : 1'h1;
            #16;
            if (!ddr) begin
                #16;
                link_clk = 1'h0;
                #16;
            end
        end
        pin_in = ~pin_in; // Released line must not echo the last bit
        #6;
    endtask

    // Clocks n bits out of the block, sampled late in each slot
    task automatic recv(input int n, output logic [7:0] w);
        w = 8'h00;
        #2;
        for (int i = 0; i < n; i++) begin
            link_clk = 1'h1;
            #32;
            link_clk = 1'h0;
            #24;
            w = {w[6:0], pin_out & ~pin_oe_b}; // Released line reads low
            #8;
        end
        #6;
    endtask

    // Free clock periods with no data of interest
    task automatic run(input int n);
        logic [7:0] d;
        recv(n, d);
    endtask
endmodule

// [bench/test_iods_top.sv]
`include "iods_map.svh"
module test_iods_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals and instances
    // ****************************************
    logic        clock;
    logic        rst_b;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        link_clk;
    logic        pin_in;
    logic        pin_out;
    logic        pin_oe_b;
    logic [7:0]  rxw;
    logic [7:0]  op_a [7] = '{8'h04, 8'h08, 8'h08, 8'h08, 8'h04, 8'h08, 8'h08};
    logic [7:0]  op_d [7] = '{8'hff, 8'h01, 8'h02, 8'h03, 8'h00, 8'h02, 8'h01};
    logic [7:0]  op_e [7] = '{8'hff, 8'hff, 8'hfe, 8'hfe, 8'h00, 8'h00, 8'h01};
    int          err_count;
    int          checks;

    iods_top #(.TAPS(256), .DEPTH(16)) dut (
        .clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .link_clk(link_clk), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_b(pin_oe_b)
    );

    iods_link_partner link (
        .link_clk(link_clk), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b)
    );

    // System clock, 8 ns period
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end

    // ****************************************
    // Access and check tasks
    // ****************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compares one seen value with its expectation
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask

    // One-cycle write strobe
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr    <= 1'h1;
        @(posedge clock);
        wr    <= 1'h0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clock);
        rd   <= 1'h0;
        #1;
        v = rdata;
    endtask

    // Reads a register and compares the masked bits
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        reg_rd(a, v);
        chk(n, v & m, e);
    endtask

    // Bounded wait on register bits
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        for (int i = 0; i < 60; i++) begin
            reg_rd(a, v);
            if ((v & m) === e) begin
                return;
            end
        end
        $display("timeout waiting on register %h", a);
        err_count++;
        stop_test();
    endtask

    // Control word from width and low flag byte
    function automatic logic [31:0] ctl(input int w, input logic [7:0] f);
        return {20'h00000, 4'(w), f};
    endfunction

    // Main sequence
    initial begin
        rst_b     = 1'h0;
        addr      = 8'h00;
        wdata     = 32'h00000000;
        wr        = 1'h0;
        rd        = 1'h0;
        err_count = 0;
        checks    = 0;
        repeat (6) @(posedge clock);
        rst_b <= 1'h1;
        @(posedge clock);
        chk("oe after reset", 32'(pin_oe_b), 32'h1);
        rd_chk("ctrl reset", `IODS_OFS_CTRL, 32'hffffffff, 32'h00000004);
        rd_chk("tap reset", `IODS_OFS_TAP, 32'hffffffff, 32'h00000000);
        reg_wr(8'h20, 32'hffffffff);
        rd_chk("unmapped", 8'h20, 32'hffffffff, 32'h00000000);
        // Receive every width; narrow ones with detector on a single-ended line
        for (int w = 2; w <= 8; w++) begin
            reg_wr(`IODS_OFS_CTRL, ctl(w, w > 4 ? 8'h21 : 8'h81 | 8'((w & 1) << 1)));
            chk("rx oe", 32'(pin_oe_b), 32'h1);
            link.send(8'ha5, w, 1'h0);
            poll(`IODS_OFS_STAT, 32'h00001fe0, 32'h00000020);
            rd_chk("rx word", `IODS_OFS_RXD, 32'h1ff, 32'h100 | (32'ha5 & ((32'h1 << w) - 1)));
        end
        rd_chk("tap held", `IODS_OFS_TAP, 32'hff, 32'h0);
        // Detector at tap 2: ignored single-ended, one step up on a pair
        reg_wr(`IODS_OFS_TAP, 32'h2);
        for (int d = 0; d < 2; d++) begin
            reg_wr(`IODS_OFS_CTRL, ctl(2, d == 0 ? 8'h81 : 8'ha1));
            link.send(8'h01, 2, 1'h0);
            poll(`IODS_OFS_STAT, 32'h00001fe0, 32'h00000020);
            rd_chk("pd word", `IODS_OFS_RXD, 32'h1ff, 32'h101);
            rd_chk("pd tap", `IODS_OFS_TAP, 32'hff, 32'h2 + 32'(d));
        end
        reg_wr(`IODS_OFS_TAP, 32'h0);
        reg_wr(`IODS_OFS_CTRL, ctl(4, 8'h09));
        link.send(8'h06, 4, 1'h1);
        poll(`IODS_OFS_STAT, 32'h00001fe0, 32'h00000020);
        rd_chk("rx both edges", `IODS_OFS_RXD, 32'h1ff, 32'h106);
        // Transmit every width; a second word while busy is dropped
        for (int w = 2; w <= 8; w++) begin
            reg_wr(`IODS_OFS_CTRL, ctl(w, w > 4 ? 8'h31 : 8'h11 | 8'((w & 1) << 2)));
            reg_wr(`IODS_OFS_TXD, 32'h5a);
            reg_wr(`IODS_OFS_TXD, 32'hff);
            chk("tx oe", 32'(pin_oe_b), 32'h0);
            link.recv(w, rxw);
            chk("tx word", 32'(rxw), 32'h5a & ((32'h1 << w) - 1));
            poll(`IODS_OFS_STAT, 32'h4, 32'h0);
        end
        // Fill the buffer past full while nobody reads, then drain it
        reg_wr(`IODS_OFS_CTRL, ctl(2, 8'h01));
        for (int i = 0; i < 17; i++) begin
            link.send(8'(i & 3), 2, 1'h0);
        end
        poll(`IODS_OFS_STAT, 32'h00001fe0, 32'h00000200);
        rd_chk("overflow", `IODS_OFS_STAT, 32'h8, 32'h8);
        for (int i = 0; i < 16; i++) begin
            rd_chk("buffer word", `IODS_OFS_RXD, 32'h1ff, 32'h100 | 32'(i & 3));
        end
        reg_wr(`IODS_OFS_STAT, 32'h0);
        rd_chk("overflow clear", `IODS_OFS_STAT, 32'h8, 32'h0);
        // Calibration over one 64 ns link period
        reg_wr(`IODS_OFS_CTRL, ctl(2, 8'h51));
        reg_wr(`IODS_OFS_STEP, 32'h4);
        link.run(3);
        poll(`IODS_OFS_STAT, 32'h1, 32'h1);
        rd_chk("cal tap", `IODS_OFS_TAP, 32'hff, 32'((64 / 8) / 2));
        // Loads, steps and both saturation ends
        for (int i = 0; i < 7; i++) begin
            reg_wr(op_a[i], 32'(op_d[i]));
            rd_chk("tap step", `IODS_OFS_TAP, 32'hff, 32'(op_e[i]));
        end
        stop_test();
    end
endmodule
